// *** core/module_reset_watchdog.sv ***
// Watchdog that resets the whole controller module when software stops restarting it.
// Assumes request pulses are synchronous to sys_clk_i and resetn_i is power-on reset.
//
// Overview of operation
// - Timeout is 1.6 seconds from arm or restart.
// - Count up only while armed.
// - Reaching timeout resets the whole module.
// - Restart request zeroes the elapsed count.
// - Disarm stops supervision; no reset until rearmed.
// - Software can read whether watchdog caused reset.
`timescale 1ns/1ps
module module_reset_watchdog #(
  parameter int unsigned TIMEOUT_CYCLES = supervisor_pkg::TIMEOUT_CYCLES
) (
  input  wire logic                                sys_clk_i,
  input  wire logic                                resetn_i,
  input  wire supervisor_pkg::supervisor_call_type calls_i,
  output logic                                     module_reset_o,
  output logic                                     reset_cause_query_o,
  output logic                                     armed_o,
  output logic [supervisor_pkg::COUNT_W-1:0]       elapsed_count_o
);

  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_sync_q;

  // Assert asynchronously, release through two flops.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Elapsed counter
  // ----------------------------------------------------------------
  logic count_clear;
  logic count_run;
  logic expired;

  elapsed_counter #(
    .COUNT_W (supervisor_pkg::COUNT_W),
    .LIMIT   (supervisor_pkg::COUNT_W'(TIMEOUT_CYCLES))
  ) u_elapsed (
    .clk_i     (sys_clk_i),
    .rst_n_i   (rst_sync_q),
    .clear_i   (count_clear),
    .run_i     (count_run),
    .count_o   (elapsed_count_o),
    .expired_o (expired)
  );

  // ----------------------------------------------------------------
  // Supervisor state machine
  // ----------------------------------------------------------------
  supervisor_pkg::supervisor_state_type state_q;
  supervisor_pkg::supervisor_state_type state_d;
  logic [supervisor_pkg::HOLD_W-1:0]    hold_q;
  logic [supervisor_pkg::HOLD_W-1:0]    hold_d;
  logic                                 module_reset_q;
  logic                                 module_reset_d;
  logic                                 cause_q;
  logic                                 cause_d;

  // The counter runs while the next state is armed, so a disarm or a timeout zeroes it
  // in the same edge that drops the armed flag; any arm or restart pulse zeroes it.
  assign count_run   = (state_d == supervisor_pkg::ST_ARMED);
  assign count_clear = calls_i.restart | calls_i.arm;

  // Disarm beats a pending timeout; a restart arriving after expiry is too late.
  always_comb begin
    state_d        = state_q;
    hold_d         = hold_q;
    module_reset_d = module_reset_q;
    cause_d        = cause_q;
    unique case (state_q)
      supervisor_pkg::ST_IDLE: begin
        if (calls_i.arm && !calls_i.disarm) begin
          state_d = supervisor_pkg::ST_ARMED;
        end
      end
      supervisor_pkg::ST_ARMED: begin
        if (calls_i.disarm) begin
          state_d = supervisor_pkg::ST_IDLE;
        end else if (expired) begin
          state_d        = supervisor_pkg::ST_RESETTING;
          module_reset_d = 1'b1;
          cause_d        = 1'b1;
          hold_d         = supervisor_pkg::RESET_PULSE_CYCLES - 5'h01;
        end
      end
      supervisor_pkg::ST_RESETTING: begin
        // Requests are ignored while the module is held in reset.
        if (hold_q == '0) begin
          state_d        = supervisor_pkg::ST_IDLE;
          module_reset_d = 1'b0;
        end else begin
          hold_d = hold_q - 5'h01;
        end
      end
    endcase
  end

  // Register the state; the cause flag only ever clears at power-on.
  always_ff @(posedge sys_clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      state_q        <= supervisor_pkg::ST_IDLE;
      hold_q         <= '0;
      module_reset_q <= 1'b0;
      cause_q        <= 1'b0;
    end else begin
      state_q        <= state_d;
      hold_q         <= hold_d;
      module_reset_q <= module_reset_d;
      cause_q        <= cause_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic armed_q;

  // Armed flag registered in step with the state.
  always_ff @(posedge sys_clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      armed_q <= 1'b0;
    end else begin
      armed_q <= (state_d == supervisor_pkg::ST_ARMED);
    end
  end

  assign armed_o             = armed_q;
  assign module_reset_o      = module_reset_q;
  assign reset_cause_query_o = cause_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  localparam logic [supervisor_pkg::COUNT_W-1:0] LIMIT_V =
    supervisor_pkg::COUNT_W'(TIMEOUT_CYCLES);

  // Arming from idle starts a fresh count.
  property p_arm_starts;
    @(posedge sys_clk_i) disable iff (!rst_sync_q)
      (state_q == supervisor_pkg::ST_IDLE && calls_i.arm && !calls_i.disarm)
        |=> (armed_o && elapsed_count_o == '0);
  endproperty
  a_arm_starts: assert property (p_arm_starts)
    else $error("arm did not start a zeroed count");

  // Nothing is counted while unarmed.
  property p_idle_no_count;
    @(posedge sys_clk_i) disable iff (!rst_sync_q)
      (!armed_o ##1 !armed_o) |-> (elapsed_count_o == '0);
  endproperty
  a_idle_no_count: assert property (p_idle_no_count)
    else $error("count moved while unarmed");

  // An undisturbed armed count rises by one each cycle below the limit.
  property p_count_up;
    @(posedge sys_clk_i) disable iff (!rst_sync_q)
      (armed_o && count_run && !count_clear && !calls_i.disarm && elapsed_count_o != LIMIT_V)
        |=> (elapsed_count_o == $past(elapsed_count_o) + supervisor_pkg::COUNT_W'(1));
  endproperty
  a_count_up: assert property (p_count_up)
    else $error("armed count did not advance");

  // The count never passes the timeout.
  property p_limit;
    @(posedge sys_clk_i) disable iff (!rst_sync_q)
      (elapsed_count_o <= LIMIT_V) && (expired == (elapsed_count_o == LIMIT_V));
  endproperty
  a_limit: assert property (p_limit)
    else $error("count passed the timeout or expiry mismatched");

  // Expiry while armed resets the module on the next edge.
  property p_timeout_reset;
    @(posedge sys_clk_i) disable iff (!rst_sync_q)
      (state_q == supervisor_pkg::ST_ARMED && expired && !calls_i.disarm)
        |=> (module_reset_o && reset_cause_query_o);
  endproperty
  a_timeout_reset: assert property (p_timeout_reset)
    else $error("timeout did not reset the module");

  // A restart while armed zeroes the count.
  property p_restart_clears;
    @(posedge sys_clk_i) disable iff (!rst_sync_q)
      (state_q == supervisor_pkg::ST_ARMED && calls_i.restart && !calls_i.disarm && !expired)
        |=> (elapsed_count_o == '0 && armed_o);
  endproperty
  a_restart_clears: assert property (p_restart_clears)
    else $error("restart did not clear the count");

  // Disarm stops supervision with no reset following.
  property p_disarm;
    @(posedge sys_clk_i) disable iff (!rst_sync_q)
      (state_q == supervisor_pkg::ST_ARMED && calls_i.disarm)
        |=> (!armed_o && !module_reset_o) ##1 !module_reset_o;
  endproperty
  a_disarm: assert property (p_disarm)
    else $error("disarm did not stop supervision");

  // The module reset stands for at least eight cycles with the cause flag set.
  property p_reset_pulse;
    @(posedge sys_clk_i) disable iff (!rst_sync_q)
      $rose(module_reset_o) |-> (module_reset_o && reset_cause_query_o)[*8];
  endproperty
  a_reset_pulse: assert property (p_reset_pulse)
    else $error("module reset pulse too short");

  // Once set, the cause flag stays until power-on reset.
  property p_cause_sticky;
    @(posedge sys_clk_i) disable iff (!rst_sync_q)
      reset_cause_query_o |=> reset_cause_query_o;
  endproperty
  a_cause_sticky: assert property (p_cause_sticky)
    else $error("reset cause flag was lost");

  // The cause flag rises only together with a module reset.
  property p_cause_source;
    @(posedge sys_clk_i) disable iff (!rst_sync_q)
      $rose(reset_cause_query_o) |-> $rose(module_reset_o);
  endproperty
  a_cause_source: assert property (p_cause_source)
    else $error("cause flag set without a watchdog reset");

endmodule

// *** core/supervisor_pkg.sv ***
// Shared constants and carrier types for the module reset watchdog.
// Assumes a single 100 MHz system clock and an active-low power-on reset.
package supervisor_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint CLK_PERIOD_NS     = 10;
  localparam longint TIMEOUT_NS        = 1_600_000_000;
  localparam int unsigned TIMEOUT_CYCLES = int'(TIMEOUT_NS / CLK_PERIOD_NS);
  localparam int unsigned COUNT_W      = 28;
  localparam int unsigned HOLD_W       = 5;
  localparam logic [4:0] RESET_PULSE_CYCLES = 5'h10;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Software requests, each a one-cycle pulse.
  typedef struct packed {
    logic arm;
    logic restart;
    logic disarm;
  } supervisor_call_type;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARMED,
    ST_RESETTING
  } supervisor_state_type;

endpackage

// *** core/elapsed_counter.sv ***
// Elapsed-time counter that saturates at its limit and flags expiry.
// Assumes clear_i and run_i are synchronous to clk_i and settle within one cycle.
`timescale 1ns/1ps
module elapsed_counter #(
  parameter int unsigned         COUNT_W = supervisor_pkg::COUNT_W,
  parameter logic [COUNT_W-1:0]  LIMIT   = COUNT_W'(supervisor_pkg::TIMEOUT_CYCLES)
) (
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               clear_i,
  input  wire logic               run_i,
  output logic [COUNT_W-1:0]      count_o,
  output logic                    expired_o
);

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  logic [COUNT_W-1:0] count_q;
  logic [COUNT_W-1:0] count_d;
  logic               expired_q;
  logic               expired_d;

  // Count up while running, hold at the limit, and zero when cleared or stopped.
  always_comb begin
    count_d   = count_q;
    expired_d = expired_q;
    if (clear_i || !run_i) begin
      count_d   = '0;
      expired_d = 1'b0;
    end else begin
      if (count_q != LIMIT) begin
        count_d = count_q + COUNT_W'(1);
      end
      expired_d = expired_q | (count_q == (LIMIT - COUNT_W'(1)));
    end
  end

  // Register the counter state.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_q   <= '0;
      expired_q <= 1'b0;
    end else begin
      count_q   <= count_d;
      expired_q <= expired_d;
    end
  end

  assign count_o   = count_q;
  assign expired_o = expired_q;

endmodule

// *** tb/module_reset_watchdog_tb.sv ***
// Self-checking testbench for the module reset watchdog.
// Assumes the design files under core/ are compiled first; the timeout is shortened.
`timescale 1ns/1ps
module module_reset_watchdog_tb;

  // ----------------------------------------------------------------
  // Signals and counters
  // ----------------------------------------------------------------
  localparam int unsigned T = 20;  // Shortened timeout in cycles.

  logic                                sys_clk_i;
  logic                                resetn_i;
  supervisor_pkg::supervisor_call_type calls_i;
  logic                                module_reset_o;
  logic                                reset_cause_query_o;
  logic                                armed_o;
  logic [supervisor_pkg::COUNT_W-1:0]  elapsed_count_o;
  int                                  fails;
  int                                  num_checks;
  int                                  cycles;

  // Device under test with a short timeout so the run stays brief.
  module_reset_watchdog #(.TIMEOUT_CYCLES(T)) i_dut (
    .sys_clk_i           (sys_clk_i),
    .resetn_i            (resetn_i),
    .calls_i             (calls_i),
    .module_reset_o      (module_reset_o),
    .reset_cause_query_o (reset_cause_query_o),
    .armed_o             (armed_o),
    .elapsed_count_o     (elapsed_count_o)
  );

  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  // Clock of 10 ns period.
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  // Cuts the run short if the sequence hangs.
  initial begin
    cycles = 0;
    forever begin
      @(posedge sys_clk_i);
      cycles++;
      if (cycles >= 5000) begin
        fails++;
        print_verdict();
      end
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Compares one value and reports a mismatch at once.
  task automatic chk(input string name, input logic [27:0] exp, input logic [27:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  // Checks armed flag, elapsed count and module reset together.
  task automatic state(input logic a, input int c, input logic r);
    chk("armed", 28'(a), 28'(armed_o));
    chk("count", c[27:0], elapsed_count_o);
    chk("module_reset", 28'(r), 28'(module_reset_o));
  endtask

  // Sends a one-cycle request; entered and left at a falling edge.
  task automatic call(input logic a, input logic r, input logic d);
    calls_i = '{arm: a, restart: r, disarm: d};
    @(negedge sys_clk_i);
    calls_i = '0;
  endtask

  // Power-on reset held for 3 cycles, then time for the internal copy to release.
  task automatic do_reset();
    resetn_i = 1'b0;
    repeat (3) @(negedge sys_clk_i);
    resetn_i = 1'b1;
    repeat (3) @(negedge sys_clk_i);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Idle: no counting, restart and disarm have no effect, cause flag clear.
  task automatic test_idle();
    chk("cause", 28'h0, 28'(reset_cause_query_o));
    call(1'b0, 1'b1, 1'b0);
    call(1'b0, 1'b0, 1'b1);
    repeat (4) begin
      state(1'b0, 0, 1'b0);
      @(negedge sys_clk_i);
    end
  endtask

  // Restarts one cycle before expiry keep the module out of reset; disarm stops it all.
  task automatic test_restart_disarm();
    call(1'b1, 1'b0, 1'b0);
    for (int n = 0; n < 3; n++) begin
      for (int k = 0; k < T - 1; k++) begin
        state(1'b1, k, 1'b0);
        @(negedge sys_clk_i);
      end
      call(1'b0, 1'b1, 1'b0);
      state(1'b1, 0, 1'b0);
    end
    repeat (5) @(negedge sys_clk_i);
    call(1'b0, 1'b0, 1'b1);
    repeat (3 * T) begin
      state(1'b0, 0, 1'b0);
      @(negedge sys_clk_i);
    end
  endtask

  // Full walk to expiry: reset pulse of 16 cycles, flag set, arm ignored meanwhile.
  task automatic test_timeout();
    call(1'b1, 1'b0, 1'b0);
    for (int k = 0; k <= T + 17; k++) begin
      if (k <= T) state(1'b1, k, 1'b0);
      else if (k <= T + 16) state(1'b0, 0, 1'b1);
      else state(1'b0, 0, 1'b0);
      chk("cause", 28'(k > T), 28'(reset_cause_query_o));
      if (k == T + 5) call(1'b1, 1'b0, 1'b0);
      else @(negedge sys_clk_i);
    end
  endtask

  // Flag survives later supervision and is cleared only by power-on reset.
  task automatic test_cause_sticky();
    call(1'b1, 1'b0, 1'b0);
    call(1'b0, 1'b1, 1'b0);
    call(1'b0, 1'b0, 1'b1);
    chk("cause", 28'h1, 28'(reset_cause_query_o));
    do_reset();
    chk("cause", 28'h0, 28'(reset_cause_query_o));
    state(1'b0, 0, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    fails = 0;
    num_checks = 0;
    resetn_i = 1'b0;
    calls_i = '0;
    do_reset();
    test_idle();
    test_restart_disarm();
    test_timeout();
    test_cause_sticky();
    print_verdict();
  end

endmodule
